// *** design/slot_ceiling_defs.vh ***
`ifndef SLOT_CEILING_DEFS_VH
`define SLOT_CEILING_DEFS_VH

// register indices; byte address is four times the index
`define TC1_IDX        12'h004
`define TC2_IDX        12'h005
`define ACLR_IDX       12'h007
`define DRDY_IDX       12'h010
`define EVT_IDX        12'h011
`define MASK_IDX       12'h012

// field layouts and reset values
`define SLOT_FIELD     16'h0fff
`define ACLR_FIELD     16'h8fff
`define ACLR_RST       16'h8fff
`define STATUS_RST     16'h0000
`define SLOT_RST       12'h000
`define IDX_RST        12'h000
`define EVT_RST        4'h0
`define FLAG_RST       1'b0
`define RDATA_IDLE     32'h0000_0000
`define BUS_READY      1'b1
`define BUS_OKAY       1'b0
`define IDX_MSB        13
`define IDX_LSB        2
`define WDAT_MSB       15
`define FIFO_BIT       15
`define NUM_SLOTS      12

// event bits of the interrupt status and mask registers
`define EVT_W          4
`define EVT_CH1        0
`define EVT_CH2        1
`define EVT_DRDY       2
`define EVT_FIFO       3
`define EVT_FIELD      16'h000f

`endif

// *** design/slot_ceiling_irq_autoclear.v ***
// Summary of operation
// [R01] slot update with channel one over threshold sets its ceiling flag; W1C only.
// [R02] slot update with channel two over threshold sets its ceiling flag; W1C only.
// [R03] channel one flags at bits 0..11, slot A at bit 0; reset zero.
// [R04] channel two flags at bits 0..11; bits 15..12 read zero.
// [R05] bit 15 enables FIFO threshold clear on every FIFO read; resets one.
// [R06] slot autoclear enable clears that slot's data-ready on its data read.
// [R07] slot autoclear enables at bits 0..11 reset one; bits 14..12 read zero.
// [R08] with autoclear off, interrupt stays set until written one.
`timescale 1ns/10ps
`include "slot_ceiling_defs.vh"

module slot_ceiling_irq_autoclear #(
    parameter NUM_SLOTS = `NUM_SLOTS
) (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    input  wire        UPDATE_STB,
    input  wire [3:0]  UPDATE_SLOT,
    input  wire        CH1_OVER,
    input  wire        CH2_OVER,
    input  wire        SLOT_READ_STB,
    input  wire [3:0]  SLOT_READ_SLOT,
    input  wire        FIFO_READ_STB,
    input  wire        FIFO_THRESHOLD_IRQ_STB,
    output wire [11:0] DATA_READY_IRQ,
    output wire        FIFO_THRESHOLD_IRQ_IRQ,
    output wire        IRQ
);

    // one-hot slot select; codes above the last slot select nothing
    function [11:0] slot_onehot;
        input [3:0] s;
        integer     i;
        begin
            slot_onehot = 12'h000;
            for (i = 0; i < NUM_SLOTS; i = i + 1)
            begin
                if (s == i[3:0])
                begin
                    slot_onehot[i] = 1'b1;
                end
            end
        end
    endfunction

    reg  [11:0]        tc1_q;
    wire [11:0]        tc1_d;
    reg  [11:0]        tc2_q;
    wire [11:0]        tc2_d;
    reg  [15:0]        aclr_q;
    reg  [15:0]        aclr_d;
    reg  [11:0]        drdy_q;
    wire [11:0]        drdy_d;
    reg                fifo_q;
    reg                fifo_d;
    reg  [`EVT_W-1:0]  evt_q;
    reg  [`EVT_W-1:0]  evt_d;
    reg  [`EVT_W-1:0]  mask_q;
    reg  [`EVT_W-1:0]  mask_d;
    reg                wr_q;
    reg                wr_d;
    reg  [11:0]        wr_idx_q;
    reg  [31:0]        rdata_q;
    reg  [31:0]        rdata_d;
    reg  [15:0]        rd_mux;
    reg                irq_q;
    reg                irq_d;
    reg                ready_q;
    reg                resp_q;
    genvar             g;

    // address phase qualifiers
    wire               addr_ok  = HSEL & HTRANS[1] & HREADY;
    wire [11:0]        idx      = HADDR[`IDX_MSB:`IDX_LSB];
    wire [15:0]        wdat     = HWDATA[`WDAT_MSB:0];
    wire [11:0]        upd_sel  = UPDATE_STB ? slot_onehot(UPDATE_SLOT) : 12'h000;
    wire [11:0]        rd_sel   = SLOT_READ_STB ? slot_onehot(SLOT_READ_SLOT) : 12'h000;
    wire [11:0]        set1     = upd_sel & {12{CH1_OVER}};
    wire [11:0]        set2     = upd_sel & {12{CH2_OVER}};
    wire               wr_tc1   = wr_q & (wr_idx_q == `TC1_IDX);
    wire               wr_tc2   = wr_q & (wr_idx_q == `TC2_IDX);
    wire               wr_aclr  = wr_q & (wr_idx_q == `ACLR_IDX);
    wire               wr_drdy  = wr_q & (wr_idx_q == `DRDY_IDX);
    wire               wr_evt   = wr_q & (wr_idx_q == `EVT_IDX);
    wire               wr_mask  = wr_q & (wr_idx_q == `MASK_IDX);
    wire [15:0]        slot_w1c = `SLOT_FIELD;
    wire [15:0]        evt_w1c  = `EVT_FIELD;
    wire [15:0]        aclr_w   = `ACLR_FIELD;
    wire [11:0]        clr1     = wr_tc1 ? (wdat[11:0] & slot_w1c[11:0]) : 12'h000;
    wire [11:0]        clr2     = wr_tc2 ? (wdat[11:0] & slot_w1c[11:0]) : 12'h000;
    wire [11:0]        clr_drdy = wr_drdy ? wdat[11:0] : 12'h000;
    wire [11:0]        auto_drdy = rd_sel & aclr_q[11:0];
    wire               auto_fifo = FIFO_READ_STB & aclr_q[`FIFO_BIT];

    // per-slot flags; a set in the same cycle as a clear wins
    generate
        for (g = 0; g < NUM_SLOTS; g = g + 1)
        begin : slot_flags
            assign tc1_d[g]  = (tc1_q[g] & ~clr1[g]) | set1[g];          // [R01] [R03]
            assign tc2_d[g]  = (tc2_q[g] & ~clr2[g]) | set2[g];          // [R02] [R04]
            assign drdy_d[g] = (drdy_q[g] & ~(clr_drdy[g] | auto_drdy[g]))
                               | upd_sel[g];                             // [R06] [R08]
        end
    endgenerate

    // fifo threshold flag; set wins over write-one and autoclear
    always @*
    begin
        fifo_d = (fifo_q & ~((wr_drdy & wdat[`FIFO_BIT]) | auto_fifo))
                 | FIFO_THRESHOLD_IRQ_STB;                                  // [R05] [R08]
    end

    // reserved enable bits never store
    always @*
    begin
        aclr_d = wr_aclr ? (wdat & aclr_w) : aclr_q;             // [R07]
    end

    always @*
    begin
        mask_d = wr_mask ? wdat[`EVT_W-1:0] : mask_q;
    end

    // event status; a new event beats its write-one clear
    always @*
    begin
        evt_d  = evt_q & ~(wr_evt ? (wdat[`EVT_W-1:0] & evt_w1c[`EVT_W-1:0])
                                  : {`EVT_W{1'b0}});
        evt_d[`EVT_CH1]  = evt_d[`EVT_CH1]  | (|set1);
        evt_d[`EVT_CH2]  = evt_d[`EVT_CH2]  | (|set2);
        evt_d[`EVT_DRDY] = evt_d[`EVT_DRDY] | (|upd_sel);
        evt_d[`EVT_FIFO] = evt_d[`EVT_FIFO] | FIFO_THRESHOLD_IRQ_STB;
    end

    // level interrupt from next state, so it moves with status
    always @*
    begin
        irq_d = |(evt_d & mask_d);
    end

    // read data stands only in the data phase
    always @*
    begin
        wr_d    = addr_ok & HWRITE;
        rdata_d = (addr_ok & ~HWRITE) ? {16'h0000, rd_mux} : `RDATA_IDLE;
    end

    // read view; reserved bits read zero
    always @*
    begin
        case (idx)
            `TC1_IDX:  rd_mux = {4'h0, tc1_q};                   // [R03]
            `TC2_IDX:  rd_mux = {4'h0, tc2_q};                   // [R04]
            `ACLR_IDX: rd_mux = aclr_q & aclr_w;                 // [R07]
            `DRDY_IDX: rd_mux = {fifo_q, 3'h0, drdy_q};
            `EVT_IDX:  rd_mux = {12'h000, evt_q};
            `MASK_IDX: rd_mux = {12'h000, mask_q};
            default:   rd_mux = 16'h0000;
        endcase
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tc1_q <= `SLOT_RST;                                  // [R03]
        end
        else
        begin
            tc1_q <= tc1_d;
        end
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tc2_q <= `SLOT_RST;                                  // [R04]
        end
        else
        begin
            tc2_q <= tc2_d;
        end
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aclr_q <= `ACLR_RST;                                 // [R05] [R07]
        end
        else
        begin
            aclr_q <= aclr_d;
        end
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            drdy_q <= `SLOT_RST;
        end
        else
        begin
            drdy_q <= drdy_d;
        end
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fifo_q <= `FLAG_RST;
        end
        else
        begin
            fifo_q <= fifo_d;
        end
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            evt_q <= `EVT_RST;
        end
        else
        begin
            evt_q <= evt_d;
        end
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mask_q <= `EVT_RST;
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    // write index held into the data phase
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_q     <= `FLAG_RST;
            wr_idx_q <= `IDX_RST;
            rdata_q  <= `RDATA_IDLE;
        end
        else
        begin
            wr_q     <= wr_d;
            wr_idx_q <= idx;
            rdata_q  <= rdata_d;
        end
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_q <= `FLAG_RST;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    // zero wait states, always okay
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ready_q <= `BUS_READY;
            resp_q  <= `BUS_OKAY;
        end
        else
        begin
            ready_q <= `BUS_READY;
            resp_q  <= `BUS_OKAY;
        end
    end

    assign HRDATA         = rdata_q;
    assign HREADYOUT      = ready_q;
    assign HRESP          = resp_q;
    assign DATA_READY_IRQ = drdy_q;
    assign FIFO_THRESHOLD_IRQ_IRQ    = fifo_q;
    assign IRQ            = irq_q;

endmodule // slot_ceiling_irq_autoclear

// *** dv/slot_ceiling_props.sv ***
`timescale 1ns/10ps
`include "slot_ceiling_defs.vh"
module slot_ceiling_props (
    input wire        CLK,
    input wire        RST_N,
    input wire        HSEL,
    input wire        HWRITE,
    input wire        HREADY,
    input wire        IRQ,
    input wire        FIFO_THRESHOLD_IRQ_IRQ,
    input wire        UPDATE_STB,
    input wire        SLOT_READ_STB,
    input wire        FIFO_READ_STB,
    input wire        FIFO_THRESHOLD_IRQ_STB,
    input wire [1:0]  HTRANS,
    input wire [3:0]  UPDATE_SLOT,
    input wire [11:0] DATA_READY_IRQ,
    input wire [31:0] HADDR,
    input wire [31:0] HRDATA
);
    reg        wr_q, rd_q;
    reg [11:0] ix_q;
    // data phase tracking
    always @(posedge CLK)
    begin
        wr_q <= HSEL & HTRANS[1] & HREADY & HWRITE;
        rd_q <= HSEL & HTRANS[1] & HREADY & ~HWRITE;
        ix_q <= HADDR[13:2];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_zero; !rd_q |-> HRDATA == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("rdata outside read");
    property p_tc2; rd_q && ix_q == `TC2_IDX |-> HRDATA[31:12] == 20'h0; endproperty
    a_tc2: assert property (p_tc2) else $error("ch2 reserved");
    property p_acl; rd_q && ix_q == `ACLR_IDX |-> HRDATA[14:12] == 3'h0; endproperty
    a_acl: assert property (p_acl) else $error("aclr reserved");
    property p_upd; UPDATE_STB && UPDATE_SLOT < 4'hc
        |=> DATA_READY_IRQ[$past(UPDATE_SLOT)]; endproperty
    a_upd: assert property (p_upd) else $error("ready not set");
    property p_fth; FIFO_THRESHOLD_IRQ_STB |=> FIFO_THRESHOLD_IRQ_IRQ; endproperty
    a_fth: assert property (p_fth) else $error("fifo flag not set");
    property p_ffl; $fell(FIFO_THRESHOLD_IRQ_IRQ) |-> $past(FIFO_READ_STB | wr_q); endproperty
    a_ffl: assert property (p_ffl) else $error("fifo flag lost");
    property p_dfl; |($past(DATA_READY_IRQ) & ~DATA_READY_IRQ)
        |-> $past(SLOT_READ_STB | wr_q); endproperty
    a_dfl: assert property (p_dfl) else $error("ready lost");
    property p_irq; $rose(IRQ) |-> $past(UPDATE_STB | FIFO_THRESHOLD_IRQ_STB | wr_q); endproperty
    a_irq: assert property (p_irq) else $error("irq no cause");
endmodule // slot_ceiling_props

// *** dv/host_model.sv ***
`timescale 1ns/10ps
module host_model (
    input wire        CLK,
    input wire        HREADYOUT,
    input wire [31:0] HRDATA,
    output reg        HSEL,
    output reg        HWRITE,
    output reg [1:0]  HTRANS,
    output reg [2:0]  HSIZE,
    output reg [31:0] HADDR,
    output reg [31:0] HWDATA
);
    initial {HSEL, HSIZE, HTRANS, HWRITE, HADDR, HWDATA} = {1'b1, 3'h2, 67'h0};
    task xfer(input w, input [11:0] ix, input [31:0] wd, output [31:0] rd);
        integer n;
        begin
            n = 0;
            HTRANS <= 2'b10;
            HWRITE <= w;
            HADDR <= {18'h0, ix, 2'h0};
            do @(posedge CLK); while (HREADYOUT !== 1'b1 && ++n < 99);
            HTRANS <= 2'b00;
            HWDATA <= wd;
            do @(posedge CLK); while (HREADYOUT !== 1'b1 && ++n < 99);
            rd = HRDATA;
            if (n >= 99) tb.wrap_up(1);
        end
    endtask
endmodule // host_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
`include "slot_ceiling_defs.vh"
module tb;
    reg         CLK = 1'b0;
    reg         RST_N = 1'b0;
    reg  [13:0] ev = 14'h0000;
    wire        HSEL, HWRITE, HREADYOUT, HRESP, FIFO_THRESHOLD_IRQ_IRQ, IRQ;
    wire [1:0]  HTRANS;
    wire [2:0]  HSIZE;
    wire [31:0] HADDR, HWDATA, HRDATA;
    wire [11:0] DATA_READY_IRQ;
    integer     bad_count = 0;
    integer     cmp_count = 0;
    reg  [31:0] r;
    always #12.5 CLK = ~CLK;
    host_model host_model_i (
        .CLK            (CLK),
        .HREADYOUT      (HREADYOUT),
        .HRDATA         (HRDATA),
        .HSEL           (HSEL),
        .HWRITE         (HWRITE),
        .HTRANS         (HTRANS),
        .HSIZE          (HSIZE),
        .HADDR          (HADDR),
        .HWDATA         (HWDATA)
    );
    slot_ceiling_irq_autoclear slot_ceiling_irq_autoclear_i (
        .CLK            (CLK),
        .RST_N          (RST_N),
        .HSEL           (HSEL),
        .HADDR          (HADDR),
        .HTRANS         (HTRANS),
        .HWRITE         (HWRITE),
        .HSIZE          (HSIZE),
        .HWDATA         (HWDATA),
        .HREADY         (HREADYOUT),
        .HRDATA         (HRDATA),
        .HREADYOUT      (HREADYOUT),
        .HRESP          (HRESP),
        .UPDATE_STB     (ev[13]),
        .UPDATE_SLOT    (ev[12:9]),
        .CH1_OVER       (ev[8]),
        .CH2_OVER       (ev[7]),
        .SLOT_READ_STB  (ev[6]),
        .SLOT_READ_SLOT (ev[5:2]),
        .FIFO_READ_STB  (ev[1]),
        .FIFO_THRESHOLD_IRQ_STB    (ev[0]),
        .DATA_READY_IRQ (DATA_READY_IRQ),
        .FIFO_THRESHOLD_IRQ_IRQ    (FIFO_THRESHOLD_IRQ_IRQ),
        .IRQ            (IRQ)
    );
    task cmp(input [31:0] g, e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e)
            begin
                bad_count = bad_count + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [11:0] ix, input [31:0] d);
        host_model_i.xfer(1'b1, ix, d, r);
    endtask
    task rc(input [11:0] ix, input [31:0] e);
        begin
            host_model_i.xfer(1'b0, ix, 32'h0, r);
            cmp(r, e);
            cmp({31'h0, HRESP}, 32'h0); // okay response
        end
    endtask
    // one-cycle event strobe, then a settle cycle
    task pl(input [13:0] e);
        begin
            ev <= e;
            @(posedge CLK);
            ev <= 14'h0000;
            @(posedge CLK);
        end
    endtask
    task wrap_up(input integer f);
        begin
            bad_count = bad_count + f;
            $display("checks %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task test_reset;
        begin
        rc(`TC1_IDX, 32'h0);
        rc(`TC2_IDX, 32'h0);
        rc(`ACLR_IDX, 32'h8fff);
        wr(`ACLR_IDX, 32'hffffffff);
        rc(`ACLR_IDX, 32'h8fff);
        wr(12'h3ff, 32'hffffffff);
        rc(12'h3ff, 32'h0);
        $display("reset test done");
        end
    endtask
    task test_ceiling;
        begin
        wr(`MASK_IDX, 32'h1);
        pl(14'h2100);
        pl(14'h2600);
        pl(14'h2a80);
        pl(14'h3780);
        pl(14'h3900);
        cmp(DATA_READY_IRQ, 32'h829);
        cmp(IRQ, 32'h1);
        rc(`TC1_IDX, 32'h801);
        rc(`TC2_IDX, 32'h820);
        wr(`TC1_IDX, 32'h1);
        wr(`TC2_IDX, 32'h0);
        rc(`TC1_IDX, 32'h800);
        rc(`TC2_IDX, 32'h820);
        wr(`EVT_IDX, 32'hf);
        @(posedge CLK);
        cmp(IRQ, 32'h0);
        $display("ceiling test done");
        end
    endtask
    task test_autoclear;
        begin
        pl(14'h004c);
        pl(14'h006c);
        cmp(DATA_READY_IRQ, 32'h021);
        wr(`ACLR_IDX, 32'h0);
        pl(14'h0040);
        pl(14'h0001);
        pl(14'h0002);
        cmp(DATA_READY_IRQ, 32'h021);
        cmp(FIFO_THRESHOLD_IRQ_IRQ, 32'h1);
        wr(`DRDY_IDX, 32'h8001);
        rc(`DRDY_IDX, 32'h20);
        wr(`ACLR_IDX, 32'h8000);
        wr(`MASK_IDX, 32'h8);
        pl(14'h0001);
        cmp(IRQ, 32'h1);
        pl(14'h0002);
        cmp(FIFO_THRESHOLD_IRQ_IRQ, 32'h0);
        wr(`MASK_IDX, 32'h0);
        @(posedge CLK);
        cmp(IRQ, 32'h0);
        $display("autoclear test done");
        end
    endtask
    initial
    begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        test_reset;
        test_ceiling;
        test_autoclear;
        wrap_up(0);
    end
endmodule // tb
bind slot_ceiling_irq_autoclear slot_ceiling_props slot_ceiling_props_i (
    .CLK            (CLK),
    .RST_N          (RST_N),
    .HSEL           (HSEL),
    .HWRITE         (HWRITE),
    .HREADY         (HREADY),
    .IRQ            (IRQ),
    .FIFO_THRESHOLD_IRQ_IRQ    (FIFO_THRESHOLD_IRQ_IRQ),
    .UPDATE_STB     (UPDATE_STB),
    .SLOT_READ_STB  (SLOT_READ_STB),
    .FIFO_READ_STB  (FIFO_READ_STB),
    .FIFO_THRESHOLD_IRQ_STB    (FIFO_THRESHOLD_IRQ_STB),
    .HTRANS         (HTRANS),
    .UPDATE_SLOT    (UPDATE_SLOT),
    .DATA_READY_IRQ (DATA_READY_IRQ),
    .HADDR          (HADDR),
    .HRDATA         (HRDATA)
);
